// *** design/sicp_defs.svh ***
/*
 Constants of the command port between a master and a slave I/O processor:
 buffer flag layout, service request layout, command codes, register offsets.
 Assumes inclusion by bare name from the package, the link monitor and the testbench.
*/
// Function
// - Master sends single-byte commands, optional data byte
// - Data-less commands: init, interrupt enable, acknowledge
// - Data byte carries transfer data, status, parameter
// - Slave accepts valid command once previous completes
// - Flags show command taken, data taken, done
// - Master polls flag byte to follow progress
// - Only hardware status byte is flag byte
// - Other status returns through ordinary data path
// - Parameters travel as ordinary data bytes
// - Completion reported as polled service request bit
// - Slave idle unless answering a command
// - Master only orders byte transfers, no timing
// - Master polls periodically for independent service requests
`ifndef SICP_DEFS_SVH
`define SICP_DEFS_SVH
// Buffer flag byte bit positions
`define SICP_FLG_OBF 0
`define SICP_FLG_IBF 1
`define SICP_FLG_CMD 2
`define SICP_FLG_DACK 3
`define SICP_FLG_DONE 4
`define SICP_FLG_BUSY 5
// Service request bits inside status byte
`define SICP_SRQ_DONE 0
`define SICP_SRQ_EXT 1
// Command codes (low nibble); bit 7 marks a command with data
`define SICP_CMD_WITHDATA_BIT 7
`define SICP_CMD_INIT 4'h0
`define SICP_CMD_INTEN 4'h1
`define SICP_CMD_INTDIS 4'h2
`define SICP_CMD_ACK 4'h3
`define SICP_CMD_STATUS 4'h4
`define SICP_CMD_WRDATA 4'h5
`define SICP_CMD_RDDATA 4'h6
`define SICP_CMD_PARAM 4'h7
`define SICP_CMD_LAST 4'h7
// Host register byte offsets
`define SICP_REG_CMD 8'h00
`define SICP_REG_DATA 8'h04
`define SICP_REG_FLAGS 8'h08
`define SICP_REG_RDATA 8'h0C
`define SICP_REG_ISTAT 8'h10
`define SICP_REG_IMASK 8'h14
// Interrupt status bits
`define SICP_IRQ_DONE 0
`define SICP_IRQ_SRQ 1
`define SICP_IRQ_W 2
`endif

// *** design/sicp_pkg.sv ***
/*
 Types for the slave I/O command port.
 Assumes sicp_defs.svh on the include path.
*/
package sicp_pkg;
   `include "sicp_defs.svh"
   // Slave engine states, Gray order along the usual path
   typedef enum logic [2:0] {
      SICP_IDLE = 3'b000,
      SICP_WAITD = 3'b001,
      SICP_EXEC = 3'b011,
      SICP_FIN = 3'b010
   } sicp_state_e;
   // Host side transaction states
   typedef enum logic [1:0] {
      SICP_H_IDLE = 2'b00,
      SICP_H_CMD = 2'b01,
      SICP_H_DAT = 2'b11
   } sicp_hstate_e;
endpackage

// *** design/sicp_if.sv ***
/*
 Byte link between master and slave: write strobes for command and data,
 flag byte and returned data byte from the slave.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/1ns
interface sicp_if;
   logic cmd_wr; // Master writes a command byte, one-cycle pulse
   logic dat_wr; // Master writes a data byte, one-cycle pulse
   logic dat_rd; // Master consumes the returned data byte, pulse
   logic [7:0] wbyte; // Byte written by master
   logic [7:0] host_byte_buffer; // Byte returned by slave
   logic [7:0] flags; // Buffer flag byte, the one hardware status byte
   modport master (output cmd_wr, dat_wr, dat_rd, wbyte,
      input host_byte_buffer, flags);
   modport slave (input cmd_wr, dat_wr, dat_rd, wbyte,
      output host_byte_buffer, flags);
endinterface

// *** design/sicp_srq.sv ***
/*
 Sticky service request byte kept by the slave, read back as data.
 Assumes the same clock and reset as the slave end.
*/
`timescale 1ns/1ns
module sicp_srq
   import sicp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [1:0] set_i,
   input wire logic [1:0] clr_i,
   output logic [7:0] srq_o
);
   logic [1:0] srq_q; // Pending requests
   // Set wins over acknowledge so no request is lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         srq_q <= 2'h0;
      end else begin
         srq_q <= (srq_q & ~clr_i) | set_i;
      end
   end
   assign srq_o = {6'h00, srq_q};
endmodule // sicp_srq

// *** design/sicp_slave.sv ***
/*
 Slave I/O processor end: takes commands and data bytes, keeps the flag
 byte, moves bytes to and from a user-side peripheral port.
 Assumes the master keeps the byte ordering of the link.
*/
`timescale 1ns/1ns
module sicp_slave
   import sicp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   sicp_if.slave lnk,
   output logic [7:0] per_wdata,
   output logic per_wr,
   output logic per_rd,
   input wire logic [7:0] per_rdata,
   input wire logic per_srq,
   output logic [7:0] per_param,
   output logic per_irq_en
);
   // The engine runs one command at a time. A command whose top bit is set
   // waits for its data byte before it executes; any other command goes
   // straight to execution. Execution and finish take one cycle each, so
   // a plain command keeps the port busy for exactly two cycles.
   // Trade-off: a fixed short execution keeps the master's polling simple,
   // but a slow peripheral must accept its strobe within one cycle.
   sicp_state_e st_q; // Engine state
   logic [7:0] cmd_q; // Command under execution
   logic [7:0] dat_q; // Data byte taken with command
   logic [7:0] out_q; // Byte returned to master
   logic obf_q; // Returned byte waiting
   logic [1:0] srq_set; // Service request set terms
   logic [1:0] srq_clr; // Service request acknowledges
   logic [7:0] srq_b; // Service request byte
   logic ext_q1, ext_q2, ext_q3; // Peripheral request synchroniser
   logic ext_prev_q; // Last agreed level of the peripheral request
   logic ext_rise; // One-cycle pulse on an agreed rising edge
   logic accept; // Command strobe while the engine is free
   logic valid; // Command code is one the engine knows

   // A command is valid when its code is known
   function automatic logic cmd_ok(input logic [7:0] c);
      cmd_ok = (c[3:0] <= `SICP_CMD_LAST);
   endfunction
   // Only ready when previous command finished
   assign accept = lnk.cmd_wr && (st_q == SICP_IDLE);
   assign valid = cmd_ok(lnk.wbyte);

   // Peripheral request comes from outside: three flops, last two agree.
   // Only the second and third stages are compared, so a level that is
   // still settling in the first stage never produces a request.
   // The idle level after reset is low, matching the pin's idle level,
   // so no false edge follows reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_q1 <= 1'b0;
         ext_q2 <= 1'b0;
         ext_q3 <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_q1 <= per_srq;
         ext_q2 <= ext_q1;
         ext_q3 <= ext_q2;
         if (ext_q2 == ext_q3) ext_prev_q <= ext_q3;
      end
   end
   assign ext_rise = (ext_q2 == ext_q3) && ext_q3 && !ext_prev_q;

   // Command engine; stays idle until a command arrives.
   // A command strobe seen outside the idle state is dropped on purpose:
   // the master must watch the busy flag before it sends the next one.
   // Unknown codes are dropped too, so a stray write cannot start work.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= SICP_IDLE;
         cmd_q <= 8'h00;
         dat_q <= 8'h00;
      end else begin
         case (st_q)
            SICP_IDLE: begin
               if (accept && valid) begin
                  cmd_q <= lnk.wbyte;
                  st_q <= lnk.wbyte[`SICP_CMD_WITHDATA_BIT] ? SICP_WAITD : SICP_EXEC;
               end
            end
            SICP_WAITD: begin
               if (lnk.dat_wr) begin
                  dat_q <= lnk.wbyte;
                  st_q <= SICP_EXEC;
               end
            end
            SICP_EXEC: st_q <= SICP_FIN;
            SICP_FIN: st_q <= SICP_IDLE;
            default: st_q <= SICP_IDLE;
         endcase
      end
   end

   // Peripheral strobes and parameters during execution.
   // Strobes are single-cycle pulses from flops, cleared every cycle
   // unless the executing command asks for one.
   // The interrupt enable level is only a request to the peripheral side;
   // the link itself never raises an interrupt, completion is polled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_wdata <= 8'h00;
         per_wr <= 1'b0;
         per_rd <= 1'b0;
         per_param <= 8'h00;
         per_irq_en <= 1'b0;
      end else begin
         per_wr <= 1'b0;
         per_rd <= 1'b0;
         if (st_q == SICP_EXEC) begin
            case (cmd_q[3:0])
               `SICP_CMD_INIT: per_irq_en <= 1'b0;
               `SICP_CMD_INTEN: per_irq_en <= 1'b1;
               `SICP_CMD_INTDIS: per_irq_en <= 1'b0;
               `SICP_CMD_WRDATA: begin
                  per_wdata <= dat_q;
                  per_wr <= 1'b1;
               end
               `SICP_CMD_RDDATA: per_rd <= 1'b1;
               `SICP_CMD_PARAM: per_param <= dat_q;
               default: per_param <= per_param;
            endcase
         end
      end
   end

   // Returned byte: status and data share one path.
   // Software tells a status byte from a data byte only by the command it
   // sent; the hardware path is identical for both.
   // A new returned byte overwrites an unread one; the master is expected
   // to read the byte before it sends the next returning command.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q <= 8'h00;
         obf_q <= 1'b0;
      end else if (st_q == SICP_EXEC && cmd_q[3:0] == `SICP_CMD_STATUS) begin
         out_q <= srq_b;
         obf_q <= 1'b1;
      end else if (st_q == SICP_EXEC && cmd_q[3:0] == `SICP_CMD_RDDATA) begin
         out_q <= per_rdata;
         obf_q <= 1'b1;
      end else if (lnk.dat_rd) begin
         obf_q <= 1'b0;
      end
   end

   // Acknowledge clears pending requests; init clears all.
   // Clear happens in execution and done is set in finish, so the
   // acknowledge of one command never hides the completion of the same.
   always_comb begin
      srq_set = 2'h0;
      srq_clr = 2'h0;
      srq_set[`SICP_SRQ_DONE] = (st_q == SICP_FIN);
      srq_set[`SICP_SRQ_EXT] = ext_rise;
      if (st_q == SICP_EXEC && (cmd_q[3:0] == `SICP_CMD_ACK ||
         cmd_q[3:0] == `SICP_CMD_INIT)) begin
         srq_clr = 2'h3;
      end
   end

   sicp_srq u_srq (
      .hclk(hclk),
      .hresetn(hresetn),
      .set_i(srq_set),
      .clr_i(srq_clr),
      .srq_o(srq_b)
   );

   // Flag byte, the only hardware status the master sees.
   // Built from state each cycle, so it follows the engine without delay.
   // Input-full and command-taken read the same today; they are kept as
   // separate bits so a deeper engine can split them later.
   // Data-taken stays set through execution and finish of a data command.
   always_comb begin
      lnk.flags = 8'h00;
      lnk.flags[`SICP_FLG_OBF] = obf_q;
      lnk.flags[`SICP_FLG_IBF] = (st_q != SICP_IDLE);
      lnk.flags[`SICP_FLG_CMD] = (st_q != SICP_IDLE);
      lnk.flags[`SICP_FLG_DACK] = (st_q == SICP_EXEC || st_q == SICP_FIN) &&
         cmd_q[`SICP_CMD_WITHDATA_BIT];
      lnk.flags[`SICP_FLG_DONE] = (st_q == SICP_IDLE);
      lnk.flags[`SICP_FLG_BUSY] = (st_q != SICP_IDLE);
   end
   assign lnk.host_byte_buffer = out_q;
endmodule // sicp_slave

// *** design/sicp_master.sv ***
/*
 Master end: AHB-Lite slave registers through which software writes commands
 and data, polls the flag byte and reads returned bytes.
 Assumes a single AHB-Lite master issuing word transfers.
*/
`timescale 1ns/1ns
module sicp_master
   import sicp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   sicp_if.master lnk
);
   logic wr_ph_q; // Write data phase pending
   logic [7:0] wa_q; // Write address
   logic [2:0] istat_q; // Sticky events
   logic [2:0] imask_q;
   logic busy_prev_q;
   logic srq_seen;
   logic req;
   // Single-cycle answers; no wait states
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign req = hsel && hready && htrans[1];

   // Write data phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_ph_q <= req && hwrite;
         wa_q <= haddr;
      end
   end

   // Link strobes; master only forwards byte orders
   always_comb begin
      lnk.cmd_wr = wr_ph_q && (wa_q == `SICP_REG_CMD);
      lnk.dat_wr = wr_ph_q && (wa_q == `SICP_REG_DATA);
      lnk.wbyte = hwdata[7:0];
   end

   // Reading the returned byte consumes it
   assign lnk.dat_rd = req && !hwrite && (haddr == `SICP_REG_RDATA);

   // Read data, registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (req && !hwrite) begin
         case (haddr)
            `SICP_REG_FLAGS: hrdata <= {24'h0, lnk.flags};
            `SICP_REG_RDATA: hrdata <= {24'h0, lnk.host_byte_buffer};
            `SICP_REG_ISTAT: hrdata <= {29'h0, istat_q};
            `SICP_REG_IMASK: hrdata <= {29'h0, imask_q};
            default: hrdata <= 32'h0;
         endcase
      end
   end

   // Done event from busy falling; returned-byte event
   assign srq_seen = lnk.flags[`SICP_FLG_OBF];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         istat_q <= 3'h0;
         imask_q <= 3'h0;
         busy_prev_q <= 1'b0;
      end else begin
         busy_prev_q <= lnk.flags[`SICP_FLG_BUSY];
         if (wr_ph_q && wa_q == `SICP_REG_IMASK) imask_q <= hwdata[2:0];
         // Set wins over write-one-to-clear
         istat_q <= (istat_q & ~((wr_ph_q && wa_q == `SICP_REG_ISTAT) ? hwdata[2:0] : 3'h0))
            | {1'b0, srq_seen, busy_prev_q && !lnk.flags[`SICP_FLG_BUSY]};
      end
   end
   assign irq = |(istat_q & imask_q);
endmodule // sicp_master

// *** verification/sicp_link_monitor.sv ***
/*
 Checker of the byte link between the master and the slave end.
 Assumes one clock, hresetn asynchronous active low, flags driven by the slave.
*/
`timescale 1ns/1ns
`include "sicp_defs.svh"
module sicp_link_monitor
   import sicp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cmd_wr,
   input wire logic dat_wr,
   input wire logic dat_rd,
   input wire logic [7:0] wbyte,
   input wire logic [7:0] host_byte_buffer,
   input wire logic [7:0] flags
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic busy; // Slave working on a command
   logic take; // Valid command offered while the slave is free
   assign busy = flags[`SICP_FLG_BUSY];
   assign take = cmd_wr && !busy && (wbyte[3:0] <= `SICP_CMD_LAST);
   // A plain command runs two busy cycles and then reports done
   sequence s_plain; take && !wbyte[`SICP_CMD_WITHDATA_BIT]; endsequence
   sequence s_finish; !busy && flags[`SICP_FLG_DONE]; endsequence
   property p_reset_flags; $rose(hresetn) |-> flags == 8'h10; endproperty
   property p_accept; take |=> busy && flags[`SICP_FLG_CMD]; endproperty
   property p_plain_done; s_plain |=> busy [*2] ##1 s_finish; endproperty
   property p_bad_code; cmd_wr && !busy && wbyte[3:0] > 4'h7 |=> !busy; endproperty
   property p_idle; !busy && !cmd_wr |=> !busy; endproperty
   property p_busy_done; busy |-> !flags[`SICP_FLG_DONE]; endproperty
   property p_data_done; busy && dat_wr |=> ##[0:3] s_finish; endproperty
   property p_obf_clear; dat_rd |=> !flags[`SICP_FLG_OBF]; endproperty
   property p_obf_hold; flags[`SICP_FLG_OBF] && !dat_rd |=> $stable(host_byte_buffer); endproperty
   a_reset_flags: assert property (p_reset_flags) else $error("flags wrong after reset");
   a_accept: assert property (p_accept) else $error("command not accepted");
   a_plain_done: assert property (p_plain_done) else $error("plain command timing wrong");
   a_bad_code: assert property (p_bad_code) else $error("unknown code accepted");
   a_idle: assert property (p_idle) else $error("slave busy without command");
   a_busy_done: assert property (p_busy_done) else $error("done shown while busy");
   a_data_done: assert property (p_data_done) else $error("data command not done");
   a_obf_clear: assert property (p_obf_clear) else $error("full flag not cleared");
   a_obf_hold: assert property (p_obf_hold) else $error("returned byte changed");
endmodule // sicp_link_monitor

// *** verification/tb.sv ***
/*
 Testbench: AHB-Lite word transfers to the master end, slave end on the link.
 Assumes a 100 MHz clock and a bus slave that never stalls for long.
*/
`timescale 1ns/1ns
`include "sicp_defs.svh"
module tb;
   import sicp_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [7:0] per_wdata, per_rdata, per_param;
   logic per_wr, per_rd, per_srq, per_irq_en, exp_irq;
   int error_cnt, compares, cyc, wr_cnt, rd_cnt;
   sicp_if sicp_if_i ();
   sicp_master sicp_master_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .lnk(sicp_if_i));
   sicp_slave sicp_slave_i (.hclk(hclk), .hresetn(hresetn), .lnk(sicp_if_i),
      .per_wdata(per_wdata), .per_wr(per_wr), .per_rd(per_rd), .per_rdata(per_rdata),
      .per_srq(per_srq), .per_param(per_param), .per_irq_en(per_irq_en));
   sicp_link_monitor sicp_link_monitor_i (.hclk(hclk), .hresetn(hresetn),
      .cmd_wr(sicp_if_i.cmd_wr), .dat_wr(sicp_if_i.dat_wr), .dat_rd(sicp_if_i.dat_rd),
      .wbyte(sicp_if_i.wbyte), .host_byte_buffer(sicp_if_i.host_byte_buffer),
      .flags(sicp_if_i.flags));
   // Free running clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Cycle ceiling cuts a hang short; peripheral write and read strobes are counted
   always @(posedge hclk) begin
      cyc++;
      if (per_wr === 1'b1) wr_cnt++;
      if (per_rd === 1'b1) rd_cnt++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   // One word transfer; entered right after a rising edge
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   // Masked read compare
   task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk("register", e, rd & m);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // Wait for the done event, check the interrupt line, clear it, check idle flags
   task automatic poll();
      int n;
      n = 0;
      do begin
         ahb(1'b0, `SICP_REG_ISTAT, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 40);
      chk("done event", 32'h1, {31'h0, rd[0]});
      chk("irq", {31'h0, exp_irq}, {31'h0, irq});
      wr(`SICP_REG_ISTAT, 32'h1);
      rdm(`SICP_REG_FLAGS, 32'h30, 32'h10);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask
   task automatic run(input logic [7:0] c, input logic [7:0] d);
      wr(`SICP_REG_CMD, {24'h0, c});
      if (c[7]) wr(`SICP_REG_DATA, {24'h0, d});
      poll();
   endtask
   initial begin
      {hsel, hwrite, per_srq} = '0;
      {haddr, htrans, hsize, hwdata, per_rdata} = '0;
      hresetn = 1'b0;
      exp_irq = 1'b1;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rdm(`SICP_REG_FLAGS, 32'hFFFFFFFF, 32'h10);
      rdm(`SICP_REG_RDATA, 32'hFFFFFFFF, 32'h0);
      rdm(8'h18, 32'hFFFFFFFF, 32'h0);
      wr(`SICP_REG_IMASK, 32'h1);
      run(8'h01, 8'h0);
      chk("irq enable", 32'h1, {31'h0, per_irq_en});
      run(8'h02, 8'h0);
      chk("irq enable", 32'h0, {31'h0, per_irq_en});
      run(8'h00, 8'h0);
      run(8'h03, 8'h0);
      per_srq <= 1'b1;
      wr(`SICP_REG_IMASK, 32'h0);
      exp_irq = 1'b0;
      run(8'h04, 8'h0);
      rdm(`SICP_REG_FLAGS, 32'h1, 32'h1);
      rdm(`SICP_REG_RDATA, 32'hFF, 32'h03);
      rdm(`SICP_REG_FLAGS, 32'h1, 32'h0);
      per_rdata <= 8'h3C;
      run(8'h06, 8'h0);
      rdm(`SICP_REG_RDATA, 32'hFF, 32'h3C);
      chk("read strobes", 32'h1, rd_cnt);
      run(8'h85, 8'hA5);
      chk("peripheral byte", 32'hA5, {24'h0, per_wdata});
      chk("write strobes", 32'h1, wr_cnt);
      run(8'h87, 8'h5A);
      chk("parameter", 32'h5A, {24'h0, per_param});
      // A second command while the first waits for its byte must be ignored
      wr(`SICP_REG_CMD, 32'h87);
      wr(`SICP_REG_CMD, 32'h00);
      wr(`SICP_REG_DATA, 32'h11);
      poll();
      chk("parameter", 32'h11, {24'h0, per_param});
      wr(`SICP_REG_CMD, 32'h0F);
      rdm(`SICP_REG_FLAGS, 32'h20, 32'h0);
      rdm(`SICP_REG_ISTAT, 32'h1, 32'h0);
      stop_test();
   end
endmodule // tb
